// ---- verilog/timer_b.sv ----
// 16-bit timer/counter with prescaler, low-frequency oscillator control and
// compare-driven period reset, reached as a classic Wishbone slave
// assumes pins are synchronous to clk_i; one device clock of 100 MHz
`timescale 1ns/1ps

// Function
// - 16-bit count in low and high bytes
// - control bit 7 selects 16-bit access
// - prescaler 1:1 to 1:8 from bits 5:4
// - bit 3 enables low-frequency oscillator
// - sync bypass bit for external source only
// - source: instruction cycle or external rising edge
// - counts only while run bit set
// - control bit 6 always reads zero
// - oscillator enabled forces pins to inputs
// - oscillator keeps running during sleep
// - wrap FFFFh to 0000h sets overflow flag
// - interrupt only when overflow enable set
// - trigger mode 1011 clears count, starts conversion
// - trigger reset never sets overflow flag
// - trigger reset skipped in asynchronous counter mode
// - count write beats same-cycle trigger reset
// - compare value acts as counter period
// - wide mode: low read latches high buffer
// - wide mode: low write loads high byte from buffer
// - low writes and non-wide high writes clear the prescaler
module timer_b (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // wishbone slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  // count sources and sleep input
  input  wire logic        ext_count_clock_pin_i,
  input  wire logic        osc_in_pin_i,
  input  wire logic        sleep_i,
  // oscillator and pin direction
  input  wire logic [1:0]  port_c_direction_i,
  output logic      [1:0]  pin_dir_o,
  output logic             osc_enable_o,
  // analog converter and interrupt
  input  wire logic        adc_enable_i,
  output logic             adc_start_o,
  output logic             irq_o
);

  logic [7:0]  ctrl_reg;
  logic [15:0] count_reg;
  logic [7:0]  high_buf_reg;
  logic        flag_reg;
  logic        irq_en_reg;
  logic [3:0]  cmp_mode_reg;
  logic [15:0] cmp_value_reg;
  logic        ack_reg;
  logic [31:0] dat_reg;
  logic [1:0]  qdiv_reg;
  logic [2:0]  presc_reg;
  logic        adc_start_reg;
  logic        irq_reg;

  logic        req;
  logic        acc;
  logic        wr;
  logic        rd;
  logic        hit_low;
  logic        hit_high;
  logic        hit_ctrl;
  logic        hit_flag;
  logic        hit_irq_en;
  logic        hit_cmp_mode;
  logic        hit_cmp_value;
  logic        wr_low;
  logic        wr_high;
  logic        rd_low;
  logic        wr_count;
  logic        wide;
  logic        run;
  logic        src_ext;
  logic        bypass;
  logic        osc_en;
  logic        async_mode;
  logic        instr_tick;
  logic        src_tick;
  logic [2:0]  presc_mask;
  logic        presc_tick;
  logic        inc;
  logic        trig;
  logic        trig_reset;
  logic        ovf;
  logic [31:0] rdata;

  ext_edge_if edge_bus ();

  // bus decode; a request is acted on at the edge where ack is high
  assign req           = cyc_i & stb_i;
  assign acc           = req & ack_reg;
  assign wr            = acc & we_i & sel_i[0];
  assign rd            = acc & ~we_i;
  assign hit_low       = (adr_i == timer_b_pkg::ADDR_COUNT_LOW);
  assign hit_high      = (adr_i == timer_b_pkg::ADDR_COUNT_HIGH);
  assign hit_ctrl      = (adr_i == timer_b_pkg::ADDR_CONTROL);
  assign hit_flag      = (adr_i == timer_b_pkg::ADDR_FLAG);
  assign hit_irq_en    = (adr_i == timer_b_pkg::ADDR_IRQ_EN);
  assign hit_cmp_mode  = (adr_i == timer_b_pkg::ADDR_CMP_MODE);
  assign hit_cmp_value = (adr_i == timer_b_pkg::ADDR_CMP_VALUE);
  assign wr_low        = wr & hit_low;
  assign wr_high       = wr & hit_high;
  assign rd_low        = rd & hit_low;

  assign wide       = ctrl_reg[timer_b_pkg::CTRL_WIDE];
  assign run        = ctrl_reg[timer_b_pkg::CTRL_RUN];
  assign src_ext    = ctrl_reg[timer_b_pkg::CTRL_SRC];
  assign bypass     = ctrl_reg[timer_b_pkg::CTRL_BYPASS];
  assign osc_en     = ctrl_reg[timer_b_pkg::CTRL_OSC];
  assign async_mode = src_ext & bypass;

  // wide mode routes high writes to buffer
  assign wr_count = wr_low | (wr_high & ~wide);

  // external source is oscillator when enabled, else the pin
  assign edge_bus.pin    = osc_en ? osc_in_pin_i : ext_count_clock_pin_i;
  assign edge_bus.bypass = bypass;

  ext_edge_detect edge_unit (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .edge_bus (edge_bus.detector)
  );

  // instruction clock halts in sleep; external edges keep counting
  assign instr_tick = (qdiv_reg == timer_b_pkg::INSTR_CYCLE_LAST) & ~sleep_i;

  // pick instruction cycle or external edge
  assign src_tick = src_ext ? edge_bus.rise : instr_tick;

  always_comb begin
    case (ctrl_reg[timer_b_pkg::CTRL_PS_HI:timer_b_pkg::CTRL_PS_LO])
      2'h0:    presc_mask = timer_b_pkg::PS_MASK_1;
      2'h1:    presc_mask = timer_b_pkg::PS_MASK_2;
      2'h2:    presc_mask = timer_b_pkg::PS_MASK_4;
      default: presc_mask = timer_b_pkg::PS_MASK_8;
    endcase
  end

  assign presc_tick = src_tick & ((presc_reg & presc_mask) == presc_mask);

  assign inc = run & presc_tick;

  // compare value is the period in trigger mode
  assign trig = (cmp_mode_reg == timer_b_pkg::CMP_TRIGGER_MODE) & (count_reg == cmp_value_reg);

  // no trigger reset on the unsynchronized path
  assign trig_reset = trig & ~async_mode;

  // a trigger or write at FFFFh is not an overflow
  assign ovf = inc & (count_reg == timer_b_pkg::COUNT_MAX) & ~trig_reset & ~wr_count;

  // instruction cycle divider, free running
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      qdiv_reg <= 2'h0;
    end else begin
      qdiv_reg <= qdiv_reg + 2'h1;
    end
  end

  // low writes clear prescaler, wide high writes do not
  always_ff @(posedge clk_i) begin
    if (rst_i || wr_count) begin
      presc_reg <= 3'h0;
    end else if (run && src_tick) begin
      presc_reg <= presc_reg + 3'h1;
    end
  end

  // count register: write first, then trigger reset, then increment
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count_reg <= timer_b_pkg::COUNT_ZERO;
    end else if (wr_low) begin
      // wide write loads high byte from buffer
      count_reg <= wide ? {high_buf_reg, dat_i[7:0]} : {count_reg[15:8], dat_i[7:0]};
    end else if (wr_high && !wide) begin
      count_reg <= {dat_i[7:0], count_reg[7:0]};
    end else if (trig_reset) begin
      // trigger only when no count write this cycle
      count_reg <= timer_b_pkg::COUNT_ZERO;
    end else if (inc) begin
      count_reg <= count_reg + 16'h0001;
    end
  end

  // high byte buffer, shared by reads and writes in wide mode
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      high_buf_reg <= 8'h00;
    end else if (wr_high && wide) begin
      high_buf_reg <= dat_i[7:0];
    end else if (rd_low && wide) begin
      // latch live high byte on low read
      high_buf_reg <= count_reg[15:8];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_reg <= timer_b_pkg::CTRL_RESET;
    end else if (wr && hit_ctrl) begin
      ctrl_reg <= dat_i[7:0] & timer_b_pkg::CTRL_WMASK;
    end
  end

  // overflow flag; hardware set beats software clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flag_reg <= 1'b0;
    end else if (ovf) begin
      flag_reg <= 1'b1;
    end else if (wr && hit_flag) begin
      flag_reg <= dat_i[timer_b_pkg::FLAG_OVF];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_en_reg    <= 1'b0;
      cmp_mode_reg  <= timer_b_pkg::CMP_MODE_RESET;
      cmp_value_reg <= timer_b_pkg::CMP_VALUE_RESET;
    end else if (wr) begin
      if (hit_irq_en) begin
        irq_en_reg <= dat_i[timer_b_pkg::IRQEN_OVF];
      end
      if (hit_cmp_mode) begin
        cmp_mode_reg <= dat_i[3:0];
      end
      if (hit_cmp_value) begin
        cmp_value_reg <= dat_i[15:0];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= (flag_reg | ovf) & irq_en_reg;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      adc_start_reg <= 1'b0;
    end else begin
      adc_start_reg <= trig_reset & adc_enable_i;
    end
  end

  // read mux; unmapped addresses read zero
  always_comb begin
    rdata = 32'h0000_0000;
    if (hit_low) begin
      rdata[7:0] = count_reg[7:0];
    end else if (hit_high) begin
      rdata[7:0] = wide ? high_buf_reg : count_reg[15:8];
    end else if (hit_ctrl) begin
      rdata[7:0] = ctrl_reg & timer_b_pkg::CTRL_WMASK;
    end else if (hit_flag) begin
      rdata[timer_b_pkg::FLAG_OVF] = flag_reg;
    end else if (hit_irq_en) begin
      rdata[timer_b_pkg::IRQEN_OVF] = irq_en_reg;
    end else if (hit_cmp_mode) begin
      rdata[3:0] = cmp_mode_reg;
    end else if (hit_cmp_value) begin
      rdata[15:0] = cmp_value_reg;
    end
  end

  // one-cycle wait: data captured as the request arrives, ack next cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
      dat_reg <= 32'h0000_0000;
    end else begin
      ack_reg <= req & ~ack_reg;
      if (req && !ack_reg) begin
        dat_reg <= rdata;
      end
    end
  end

  assign dat_o        = dat_reg;
  assign ack_o        = ack_reg;
  assign irq_o        = irq_reg;
  assign adc_start_o  = adc_start_reg;
  assign osc_enable_o = osc_en;
  // pins forced to inputs under the oscillator
  assign pin_dir_o    = osc_en ? 2'h3 : port_c_direction_i;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  sequence s_req_start;
    cyc_i && stb_i && !ack_reg;
  endsequence

  sequence s_ack_pulse;
    ack_reg ##1 !ack_reg;
  endsequence

  sequence s_wide_low_write;
    wr_low && wide;
  endsequence

  a_bus_ack_pulse: assert property (s_req_start |=> s_ack_pulse)
    else $error("ack not a single pulse one cycle after request");

  a_overflow_sets_flag: assert property (ovf |=> flag_reg)
    else $error("overflow did not set flag");

  a_irq_follows_flag: assert property (ovf && irq_en_reg && !(wr && hit_irq_en) |=> ##1 irq_o)
    else $error("enabled overflow gave no interrupt");

  a_irq_masked_off: assert property (!irq_en_reg && !(wr && hit_irq_en) |=> !irq_o)
    else $error("interrupt raised while disabled");

  a_trigger_clears: assert property (trig_reset && !wr_count |=> count_reg == 16'h0000)
    else $error("trigger did not clear count");

  a_trigger_no_flag: assert property (trig_reset && !flag_reg && !(wr && hit_flag) |=> !flag_reg)
    else $error("trigger reset set overflow flag");

  a_write_beats_trig: assert property (wr_low && trig |=> count_reg[7:0] == $past(dat_i[7:0]))
    else $error("trigger overrode software write");

  a_stop_holds: assert property (!run && !wr_count && !trig_reset |=> $stable(count_reg))
    else $error("count moved while stopped");

  a_ctrl_bit_zero: assert property (ack_reg && hit_ctrl && !we_i |-> !dat_o[6])
    else $error("unused control bit read as one");

  a_wide_read_latch: assert property (rd_low && wide |=> high_buf_reg == $past(count_reg[15:8]))
    else $error("low read did not latch high byte");

  a_wide_write_load: assert property (s_wide_low_write |=> count_reg[15:8] == $past(high_buf_reg))
    else $error("low write did not load high from buffer");

  a_wide_high_presc: assert property (wr_high && wide && presc_reg != 3'h0 && !(run && src_tick)
                                      |=> $stable(presc_reg))
    else $error("buffer write disturbed prescaler");

  a_osc_pin_inputs: assert property (osc_en |-> pin_dir_o == 2'h3)
    else $error("oscillator pins not forced to inputs");

  a_osc_in_sleep: assert property (sleep_i && osc_en && !(wr && hit_ctrl) |=> osc_enable_o)
    else $error("oscillator stopped during sleep");

endmodule

// ---- verilog/timer_b_pkg.sv ----
// constants for the 16-bit timer/counter: register map, control fields, counts
// assumes a 32-bit classic Wishbone slave with byte addresses on adr_i
package timer_b_pkg;

  // register byte addresses, one aligned word each
  localparam logic [7:0] ADDR_COUNT_LOW  = 8'h00;
  localparam logic [7:0] ADDR_COUNT_HIGH = 8'h04;
  localparam logic [7:0] ADDR_CONTROL    = 8'h08;
  localparam logic [7:0] ADDR_FLAG       = 8'h0C;
  localparam logic [7:0] ADDR_IRQ_EN     = 8'h10;
  localparam logic [7:0] ADDR_CMP_MODE   = 8'h14;
  localparam logic [7:0] ADDR_CMP_VALUE  = 8'h18;

  // timer_b_control field positions
  localparam int CTRL_WIDE   = 7;
  localparam int CTRL_UNUSED = 6;
  localparam int CTRL_PS_HI  = 5;
  localparam int CTRL_PS_LO  = 4;
  localparam int CTRL_OSC    = 3;
  localparam int CTRL_BYPASS = 2;
  localparam int CTRL_SRC    = 1;
  localparam int CTRL_RUN    = 0;

  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] CTRL_WMASK = 8'hBF;

  // flag and enable bit positions
  localparam int FLAG_OVF  = 0;
  localparam int IRQEN_OVF = 0;

  // compare unit
  localparam logic [3:0] CMP_TRIGGER_MODE = 4'hB;
  localparam logic [3:0] CMP_MODE_RESET   = 4'h0;
  localparam logic [15:0] CMP_VALUE_RESET = 16'h0000;

  // counts
  localparam logic [1:0]  INSTR_CYCLE_LAST = 2'h3;
  localparam logic [15:0] COUNT_MAX        = 16'hFFFF;
  localparam logic [15:0] COUNT_ZERO       = 16'h0000;

  // prescaler masks for 1:1, 1:2, 1:4, 1:8
  localparam logic [2:0] PS_MASK_1 = 3'h0;
  localparam logic [2:0] PS_MASK_2 = 3'h1;
  localparam logic [2:0] PS_MASK_4 = 3'h3;
  localparam logic [2:0] PS_MASK_8 = 3'h7;

endpackage

// ---- verilog/ext_edge_if.sv ----
// carrier between the timer core and its external edge detector
// assumes both ends sit on the same device clock
`timescale 1ns/1ps
interface ext_edge_if;
  logic pin;
  logic bypass;
  logic rise;

  modport detector (
    input  pin,
    input  bypass,
    output rise
  );
  modport user (
    output pin,
    output bypass,
    input  rise
  );
endinterface

// ---- verilog/ext_edge_detect.sv ----
// rising-edge detector for the external count source
// assumes the pin level is sampled on clk_i; bypass picks the short path
`timescale 1ns/1ps
module ext_edge_detect (
  // clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // edge carrier
  ext_edge_if.detector edge_bus
);

  logic sync1_reg;
  logic sync2_reg;
  logic sync3_reg;
  logic fast1_reg;
  logic fast2_reg;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
      sync3_reg <= 1'b0;
    end else begin
      sync1_reg <= edge_bus.pin;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
    end
  end

  // single sample, one cycle less latency, no metastability margin
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fast1_reg <= 1'b0;
      fast2_reg <= 1'b0;
    end else begin
      fast1_reg <= edge_bus.pin;
      fast2_reg <= fast1_reg;
    end
  end

  assign edge_bus.rise = edge_bus.bypass ? (fast1_reg & ~fast2_reg) : (sync2_reg & ~sync3_reg);

endmodule

// ---- tb/ext_clock_model.sv ----
// behavioural far-side count source: external clock pin or low-frequency crystal
// assumes clk_i is the device clock; the half period is half_i plus one device clocks
`timescale 1ns/1ps
module ext_clock_model (
  // clock and control
  input  wire logic       clk_i,
  input  wire logic       run_i,
  input  wire logic [7:0] half_i,
  // far-side pin and edge tally
  output logic            pin_o,
  output logic [15:0]     edges_o
);
  logic [7:0] tick_reg;

  initial begin
    pin_o = 1'b0;
    edges_o = 16'h0000;
    tick_reg = 8'h00;
  end

  // clock stands low between bursts, so no stray edge is counted
  always @(posedge clk_i) begin
    if (!run_i) begin
      pin_o <= 1'b0;
      tick_reg <= 8'h00;
    end else if (tick_reg == half_i) begin
      tick_reg <= 8'h00;
      pin_o <= ~pin_o;
      if (!pin_o) begin
        edges_o <= edges_o + 16'h0001;
      end
    end else begin
      tick_reg <= tick_reg + 8'h01;
    end
  end
endmodule

// ---- tb/testbench.sv ----
// self-checking bench for the 16-bit timer/counter
// assumes the design answers each Wishbone request with a one-cycle ack
`timescale 1ns/1ps
module testbench;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0;
  logic [7:0]  wb_adr = 8'h00;
  logic [3:0]  wb_sel = 4'h0;
  logic [31:0] wb_dat = 32'h0, rdata, dat_o;
  logic        ack_o, sleep = 1'b0, adc_en = 1'b0, ext_run = 1'b0;
  logic [1:0]  port_dir = 2'h1, pin_dir_o;
  logic        osc_enable_o, adc_start_o, irq_o, pin;
  logic [15:0] edges;
  int          bad_count = 0, check_count = 0;

  always #5 clk_i = ~clk_i;

  timer_b u_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(wb_cyc), .stb_i(wb_stb), .we_i(wb_we),
    .adr_i(wb_adr), .sel_i(wb_sel), .dat_i(wb_dat), .dat_o(dat_o), .ack_o(ack_o),
    .ext_count_clock_pin_i(pin), .osc_in_pin_i(pin), .sleep_i(sleep),
    .port_c_direction_i(port_dir), .pin_dir_o(pin_dir_o), .osc_enable_o(osc_enable_o),
    .adc_enable_i(adc_en), .adc_start_o(adc_start_o), .irq_o(irq_o));

  ext_clock_model u_src (.clk_i(clk_i), .run_i(ext_run), .half_i(8'h04), .pin_o(pin), .edges_o(edges));

  task end_of_test;
    if (bad_count == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task check_val(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task check_near(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
    check_count++;
    if ((got >= lo && got <= hi) !== 1'b1) begin
      bad_count++;
      $display("CHECK FAILED at %0t: got %h expected %h to %h", $time, got, lo, hi);
    end
  endtask

  // one classic cycle; request held until ack is sampled, then one idle cycle
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= w;
    wb_sel <= 4'hF;
    wb_adr <= a;
    wb_dat <= d;
    @(posedge clk_i);
    while (ack_o !== 1'b1 && n < 16) begin
      @(posedge clk_i);
      n++;
    end
    rdata = dat_o;
    if (n == 16) begin
      bad_count++;
      end_of_test();
    end
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we <= 1'b0;
    wb_sel <= 4'h0;
    @(posedge clk_i);
  endtask

  task wait_clks(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  task set_count(input logic [7:0] hi, input logic [7:0] lo);
    wb(1'b1, timer_b_pkg::ADDR_COUNT_HIGH, {24'h0, hi});
    wb(1'b1, timer_b_pkg::ADDR_COUNT_LOW, {24'h0, lo});
  endtask

  task run_edges(input int n);
    int i;
    logic [15:0] e0;
    i = 0;
    e0 = edges;
    ext_run <= 1'b1;
    while (edges !== e0 + n[15:0] && i < 1000) begin
      @(posedge clk_i);
      i++;
    end
    ext_run <= 1'b0;
    if (i == 1000) begin
      bad_count++;
      end_of_test();
    end
    wait_clks(8);
  endtask

  task t_reset_vals;
    check_val({29'h0, irq_o, adc_start_o, osc_enable_o}, 32'h0);
    check_val({30'h0, pin_dir_o}, 32'h1);
    wb(1'b0, timer_b_pkg::ADDR_CONTROL, 32'h0);
    check_val(rdata, {24'h0, timer_b_pkg::CTRL_RESET});
    wb(1'b1, timer_b_pkg::ADDR_CONTROL, 32'h40);
    wb(1'b0, timer_b_pkg::ADDR_CONTROL, 32'h0);
    check_val(rdata, 32'h0);
    wb(1'b0, 8'h3C, 32'h0);
    check_val(rdata, 32'h0);
  endtask

  task t_prescale;
    logic [31:0] exp;
    for (int p = 0; p < 4; p++) begin
      exp = 32'd64 >> p;
      set_count(8'h00, 8'h00);
      wb(1'b1, timer_b_pkg::ADDR_CONTROL, (p << 4) | 1);
      wait_clks(256);
      wb(1'b1, timer_b_pkg::ADDR_CONTROL, 32'h0);
      wb(1'b0, timer_b_pkg::ADDR_COUNT_LOW, 32'h0);
      check_near(rdata, exp - 2, exp + 3);
      exp = rdata;
      wait_clks(40);
      wb(1'b0, timer_b_pkg::ADDR_COUNT_LOW, 32'h0);
      check_val(rdata, exp);
    end
  endtask

  task t_overflow;
    wb(1'b1, timer_b_pkg::ADDR_IRQ_EN, 32'h0);
    wb(1'b1, timer_b_pkg::ADDR_FLAG, 32'h0);
    set_count(8'hFF, 8'hF0);
    wb(1'b1, timer_b_pkg::ADDR_CONTROL, 32'h1);
    wait_clks(100);
    wb(1'b1, timer_b_pkg::ADDR_CONTROL, 32'h0);
    wb(1'b0, timer_b_pkg::ADDR_FLAG, 32'h0);
    check_val(rdata, 32'h1);
    wb(1'b0, timer_b_pkg::ADDR_COUNT_HIGH, 32'h0);
    check_val(rdata, 32'h0);
    check_val({31'h0, irq_o}, 32'h0);
    wb(1'b1, timer_b_pkg::ADDR_IRQ_EN, 32'h1);
    wait_clks(2);
    check_val({31'h0, irq_o}, 32'h1);
    wb(1'b1, timer_b_pkg::ADDR_FLAG, 32'h0);
    wait_clks(2);
    check_val({31'h0, irq_o}, 32'h0);
  endtask

  task t_wide;
    wb(1'b1, timer_b_pkg::ADDR_CONTROL, 32'h80);
    set_count(8'h12, 8'h34);
    wb(1'b1, timer_b_pkg::ADDR_COUNT_HIGH, 32'h56);
    wb(1'b0, timer_b_pkg::ADDR_COUNT_LOW, 32'h0);
    check_val(rdata, 32'h34);
    wb(1'b0, timer_b_pkg::ADDR_COUNT_HIGH, 32'h0);
    check_val(rdata, 32'h12);
    // buffer writes every 19 clocks would starve a 1:8 prescaler if they cleared it
    wb(1'b1, timer_b_pkg::ADDR_CONTROL, 32'hB1);
    wb(1'b1, timer_b_pkg::ADDR_COUNT_LOW, 32'h0);
    repeat (12) begin
      wait_clks(16);
      wb(1'b1, timer_b_pkg::ADDR_COUNT_HIGH, 32'h0);
    end
    wb(1'b1, timer_b_pkg::ADDR_CONTROL, 32'h80);
    wb(1'b0, timer_b_pkg::ADDR_COUNT_LOW, 32'h0);
    check_near(rdata, 32'd5, 32'd9);
    wb(1'b1, timer_b_pkg::ADDR_CONTROL, 32'h0);
    wb(1'b1, timer_b_pkg::ADDR_COUNT_HIGH, 32'h77);
    wb(1'b0, timer_b_pkg::ADDR_COUNT_HIGH, 32'h0);
    check_val(rdata, 32'h77);
  endtask

  task t_external;
    set_count(8'h00, 8'h00);
    wb(1'b1, timer_b_pkg::ADDR_CONTROL, 32'h03);
    run_edges(10);
    wb(1'b0, timer_b_pkg::ADDR_COUNT_LOW, 32'h0);
    check_val(rdata, 32'd10);
    // unsynchronized path: count runs past the compare value untouched
    set_count(8'h00, 8'h00);
    wb(1'b1, timer_b_pkg::ADDR_CMP_VALUE, 32'h3);
    wb(1'b1, timer_b_pkg::ADDR_CMP_MODE, {28'h0, timer_b_pkg::CMP_TRIGGER_MODE});
    wb(1'b1, timer_b_pkg::ADDR_CONTROL, 32'h07);
    run_edges(6);
    wb(1'b0, timer_b_pkg::ADDR_COUNT_LOW, 32'h0);
    check_val(rdata, 32'd6);
    wb(1'b1, timer_b_pkg::ADDR_CMP_MODE, 32'h0);
    set_count(8'h00, 8'h00);
    sleep <= 1'b1;
    port_dir <= 2'h2;
    wb(1'b1, timer_b_pkg::ADDR_CONTROL, 32'h0B);
    check_val({30'h0, pin_dir_o}, 32'h3);
    check_val({31'h0, osc_enable_o}, 32'h1);
    run_edges(6);
    wb(1'b0, timer_b_pkg::ADDR_COUNT_LOW, 32'h0);
    check_val(rdata, 32'd6);
    sleep <= 1'b0;
    wb(1'b1, timer_b_pkg::ADDR_CONTROL, 32'h0);
    check_val({31'h0, osc_enable_o}, 32'h0);
    check_val({30'h0, pin_dir_o}, 32'h2);
  endtask

  task t_trigger;
    int i;
    i = 0;
    wb(1'b1, timer_b_pkg::ADDR_FLAG, 32'h0);
    set_count(8'h00, 8'h00);
    wb(1'b1, timer_b_pkg::ADDR_CMP_VALUE, 32'h5);
    wb(1'b1, timer_b_pkg::ADDR_CMP_MODE, {28'h0, timer_b_pkg::CMP_TRIGGER_MODE});
    adc_en <= 1'b1;
    wb(1'b1, timer_b_pkg::ADDR_CONTROL, 32'h1);
    while (adc_start_o !== 1'b1 && i < 200) begin
      @(posedge clk_i);
      i++;
    end
    check_near(i, 0, 199);
    wait_clks(100);
    wb(1'b1, timer_b_pkg::ADDR_CONTROL, 32'h0);
    wb(1'b0, timer_b_pkg::ADDR_COUNT_LOW, 32'h0);
    check_near(rdata, 0, 5);
    wb(1'b0, timer_b_pkg::ADDR_FLAG, 32'h0);
    check_val(rdata, 32'h0);
    // period end at FFFFh: the restart must not look like an overflow
    wb(1'b1, timer_b_pkg::ADDR_CMP_VALUE, 32'hFFFF);
    set_count(8'hFF, 8'hF0);
    wb(1'b1, timer_b_pkg::ADDR_CONTROL, 32'h1);
    wait_clks(100);
    wb(1'b1, timer_b_pkg::ADDR_CONTROL, 32'h0);
    wb(1'b0, timer_b_pkg::ADDR_FLAG, 32'h0);
    check_val(rdata, 32'h0);
    // count held at the match, so every cycle carries a trigger
    wb(1'b1, timer_b_pkg::ADDR_CMP_VALUE, 32'h0);
    set_count(8'h00, 8'h00);
    wb(1'b1, timer_b_pkg::ADDR_COUNT_LOW, 32'h7);
    wb(1'b0, timer_b_pkg::ADDR_COUNT_LOW, 32'h0);
    check_val(rdata, 32'h7);
    wb(1'b1, timer_b_pkg::ADDR_CMP_MODE, 32'h0);
  endtask

  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_reset_vals();
    t_prescale();
    t_overflow();
    t_wide();
    t_external();
    t_trigger();
    end_of_test();
  end
endmodule
